//--- src/pixel_buffer_defs.vh
// Purpose: shared constants for the packed pixel buffer and identification block
// Assumes: included by bare name from design files
// Notes: field positions are bit indices inside the 32-bit identification word
`ifndef PIXEL_BUFFER_DEFS_VH
`define PIXEL_BUFFER_DEFS_VH

// register offsets on the register read port
`define PRODUCT_INFO_OFS 8'h00

// identification word field positions
`define PI_REV_LO_MSB 1
`define PI_REV_LO_LSB 0
`define PI_PROD_LO_MSB 7
`define PI_PROD_LO_LSB 2
`define PI_SIZE_MSB 15
`define PI_SIZE_LSB 8
`define PI_STRAP_MSB 22
`define PI_STRAP_LSB 16
`define PI_REV_HI_MSB 25
`define PI_REV_HI_LSB 24
`define PI_PROD_HI_MSB 31
`define PI_PROD_HI_LSB 26

// display buffer size in bytes
`define BUF_BYTES 163840
`define BUF_ADDR_W 18

// colour depth select codes
`define BPP_1 3'h0
`define BPP_2 3'h1
`define BPP_4 3'h2
`define BPP_8 3'h3
`define BPP_16 3'h4

// reset values
`define STRAP_RESET 7'h00
`define PIX_RESET 16'h0000

`endif

//--- src/pixel_unpacker.v
// Purpose: pick one pixel out of a packed buffer byte or byte pair
// Assumes: sel is below the pixel count of the chosen depth
// Notes: purely combinational; the caller registers the result
`timescale 1ns/10ps
`include "pixel_buffer_defs.vh"

module pixel_unpacker (
  bpp_sel,
  word_in,
  sel,
  pixel
);
  input wire [2:0] bpp_sel;
  input wire [15:0] word_in;
  input wire [2:0] sel;
  output reg [15:0] pixel;

  wire [7:0] byte_in;

  assign byte_in = word_in[7:0];

  always @* begin
    pixel = `PIX_RESET;
    case (bpp_sel)
      // leftmost pixel sits in the top bits, the next one to its right below it
      `BPP_1: pixel = {15'h0000, byte_in[3'h7 - sel]}; // R7 R8 R10
      `BPP_2: begin
        case (sel[1:0])
          2'h0: pixel = {14'h0000, byte_in[7:6]}; // R9 R11
          2'h1: pixel = {14'h0000, byte_in[5:4]}; // R9
          2'h2: pixel = {14'h0000, byte_in[3:2]}; // R9
          default: pixel = {14'h0000, byte_in[1:0]}; // R9
        endcase
      end
      `BPP_4: pixel = sel[0] ? {12'h000, byte_in[3:0]} : {12'h000, byte_in[7:4]}; // R6 R7
      `BPP_8: pixel = {8'h00, byte_in}; // R6
      `BPP_16: pixel = word_in; // R6
      default: pixel = `PIX_RESET;
    endcase
  end
endmodule // pixel_unpacker

//--- src/packed_pixel_buffer_id.v
// Purpose: embedded display buffer with host byte port, pixel unpacker and id word
// Assumes: host and scan inputs synchronous to core_clk; strap pins stable during reset
// Notes: scan side streams look-up indices with valid/ready; 16 bpp is a bypass word
// Contract
// R1: the identification word carries the six-bit product code in bits 7-2 and again in 31-26.
// R2: the identification word carries the two-bit revision in bits 1-0 and again in 25-24.
// R3: the identification word reports the buffer size as an eight-bit field in bits 15-8.
// R4: bits 22-16 of the identification word show the seven configuration strap levels.
// R5: a 160K byte buffer is read and written directly by the host as memory space.
// R6: the unpacker handles 1, 2, 4, 8 and 16 bits per pixel with no padding between pixels.
// R7: the leftmost pixel comes from the top bits of a byte, later pixels from lower bits.
// R8: at 1 bpp a byte gives eight pixels, pixel 0 from bit 7 and pixel 7 from bit 0.
// R9: at 2 bpp a byte gives four pixels in bits 7-6, 5-4, 3-2 and 1-0.
// R10: at 1 bpp the index reaches only look-up entries 0 and 1, green only on mono panels.
// R11: at 2 bpp the index reaches only look-up entries 0 to 3, green only on mono panels.
// R12: the host changes one small pixel by reading the byte, merging and writing it back.
// R13: the unpacker fetches bytes at ascending addresses for pixels running left to right.
`timescale 1ns/10ps
`include "pixel_buffer_defs.vh"

module packed_pixel_buffer_id #(
  parameter BUF_DEPTH = `BUF_BYTES,
  parameter [5:0] PRODUCT_CODE = 6'h15, // arbitrary value
  parameter [1:0] REVISION_CODE = 2'h1, // arbitrary value
  parameter [7:0] BUF_SIZE_CODE = 8'h11 // arbitrary value
) (
  core_clk,
  srst,
  config_strap_pins,
  host_cs,
  host_we,
  host_addr,
  host_wdata,
  host_rdata,
  host_rvalid,
  reg_rd,
  reg_addr,
  reg_rdata,
  reg_rvalid,
  scan_start,
  scan_base,
  scan_count,
  bpp_sel,
  mono_panel,
  scan_busy,
  pix_valid,
  pix_ready,
  pix_data,
  pix_bypass,
  pix_green_only
);
  input wire core_clk;
  input wire srst;
  input wire [6:0] config_strap_pins;
  input wire host_cs;
  input wire host_we;
  input wire [`BUF_ADDR_W-1:0] host_addr;
  input wire [7:0] host_wdata;
  output reg [7:0] host_rdata;
  output reg host_rvalid;
  input wire reg_rd;
  input wire [7:0] reg_addr;
  output reg [31:0] reg_rdata;
  output reg reg_rvalid;
  input wire scan_start;
  input wire [`BUF_ADDR_W-1:0] scan_base;
  input wire [`BUF_ADDR_W-1:0] scan_count;
  input wire [2:0] bpp_sel;
  input wire mono_panel;
  output wire scan_busy;
  output wire pix_valid;
  input wire pix_ready;
  output reg [15:0] pix_data;
  output reg pix_bypass;
  output reg pix_green_only;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_PREP = 2'h2;
  localparam [1:0] ST_SHOW = 2'h3;

  // last pixel slot inside one fetched byte (or byte pair at 16 bpp)
  function [2:0] last_slot;
    input [2:0] bpp;
    begin
      case (bpp)
        `BPP_1: last_slot = 3'h7; // R8
        `BPP_2: last_slot = 3'h3; // R9
        `BPP_4: last_slot = 3'h1;
        default: last_slot = 3'h0;
      endcase
    end
  endfunction

  function in_range;
    input [`BUF_ADDR_W-1:0] addr;
    begin
      in_range = ({14'h0000, addr} < BUF_DEPTH);
    end
  endfunction

  reg [7:0] mem [0:BUF_DEPTH-1];
  reg [6:0] strap_reg;
  reg [1:0] state_reg;
  reg [`BUF_ADDR_W-1:0] fetch_addr_reg;
  reg [`BUF_ADDR_W-1:0] remain_reg;
  reg [15:0] word_reg;
  reg half_reg;
  reg [2:0] slot_reg;
  reg [2:0] bpp_reg;
  reg mono_reg;
  reg valid_reg;
  wire [31:0] product_info;
  wire [2:0] unpack_sel;
  wire [15:0] unpacked;
  wire take;
  wire last_pix;

  // straps are sampled while reset is held, then frozen
  always @(posedge core_clk) begin
    if (srst) begin
      strap_reg <= config_strap_pins; // R4
    end
  end

  assign product_info[`PI_PROD_HI_MSB:`PI_PROD_HI_LSB] = PRODUCT_CODE; // R1
  assign product_info[`PI_REV_HI_MSB:`PI_REV_HI_LSB] = REVISION_CODE; // R2
  assign product_info[23] = 1'b0;
  assign product_info[`PI_STRAP_MSB:`PI_STRAP_LSB] = strap_reg; // R4
  assign product_info[`PI_SIZE_MSB:`PI_SIZE_LSB] = BUF_SIZE_CODE; // R3
  assign product_info[`PI_PROD_LO_MSB:`PI_PROD_LO_LSB] = PRODUCT_CODE; // R1
  assign product_info[`PI_REV_LO_MSB:`PI_REV_LO_LSB] = REVISION_CODE; // R2

  // register read port; unmapped offsets read as zero
  always @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= (reg_addr == `PRODUCT_INFO_OFS) ? product_info : 32'h00000000; // R1 R3
      end
    end
  end

  // host byte port; a pixel update is a read-merge-write done by software
  always @(posedge core_clk) begin
    if (host_cs && host_we && in_range(host_addr)) begin
      mem[host_addr] <= host_wdata; // R5 R12
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_cs && !host_we;
      if (host_cs && !host_we) begin
        host_rdata <= in_range(host_addr) ? mem[host_addr] : 8'h00; // R5
      end
    end
  end

  assign take = valid_reg && pix_ready;
  assign last_pix = (remain_reg == {{(`BUF_ADDR_W-1){1'b0}}, 1'b1});
  assign unpack_sel = (state_reg == ST_PREP) ? 3'h0 : slot_reg + 3'h1;
  assign scan_busy = (state_reg != ST_IDLE);
  assign pix_valid = valid_reg;

  pixel_unpacker u_unpack (
    .bpp_sel(bpp_reg),
    .word_in(word_reg),
    .sel(unpack_sel),
    .pixel(unpacked)
  );

  // scan engine: fetch, unpack, hand pixels out one at a time
  always @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      fetch_addr_reg <= {`BUF_ADDR_W{1'b0}};
      remain_reg <= {`BUF_ADDR_W{1'b0}};
      word_reg <= 16'h0000;
      half_reg <= 1'b0;
      slot_reg <= 3'h0;
      bpp_reg <= `BPP_1;
      mono_reg <= 1'b0;
      valid_reg <= 1'b0;
      pix_data <= `PIX_RESET;
      pix_bypass <= 1'b0;
      pix_green_only <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // depth and panel type latch at start so a frame never mixes layouts
          if (scan_start && scan_count != {`BUF_ADDR_W{1'b0}}) begin
            fetch_addr_reg <= scan_base;
            remain_reg <= scan_count;
            bpp_reg <= bpp_sel;
            mono_reg <= mono_panel;
            half_reg <= 1'b0;
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          // out of range fetches read as zero rather than wrapping
          fetch_addr_reg <= fetch_addr_reg + {{(`BUF_ADDR_W-1){1'b0}}, 1'b1}; // R13
          if (bpp_reg == `BPP_16 && !half_reg) begin
            // first byte of the pair is the low half of the 16-bit word
            word_reg[7:0] <= in_range(fetch_addr_reg) ? mem[fetch_addr_reg] : 8'h00; // R6
            half_reg <= 1'b1;
          end else if (bpp_reg == `BPP_16) begin
            word_reg[15:8] <= in_range(fetch_addr_reg) ? mem[fetch_addr_reg] : 8'h00; // R6
            half_reg <= 1'b0;
            state_reg <= ST_PREP;
          end else begin
            word_reg <= {8'h00, in_range(fetch_addr_reg) ? mem[fetch_addr_reg] : 8'h00};
            state_reg <= ST_PREP;
          end
        end
        ST_PREP: begin
          pix_data <= unpacked; // R7
          pix_bypass <= (bpp_reg == `BPP_16);
          pix_green_only <= mono_reg; // R10 R11
          slot_reg <= 3'h0;
          valid_reg <= 1'b1;
          state_reg <= ST_SHOW;
        end
        ST_SHOW: begin
          if (take) begin
            remain_reg <= remain_reg - {{(`BUF_ADDR_W-1){1'b0}}, 1'b1};
            if (last_pix) begin
              valid_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else if (slot_reg == last_slot(bpp_reg)) begin
              // byte used up, move on to the next one with no gap bits
              valid_reg <= 1'b0;
              state_reg <= ST_READ; // R6 R13
            end else begin
              slot_reg <= slot_reg + 3'h1;
              pix_data <= unpacked; // R7 R8 R9
            end
          end
        end
        default: begin
          valid_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // packed_pixel_buffer_id

//--- sim/packed_pixel_buffer_id_assertions.sv
// Purpose: port-level checks for the pixel buffer block
// Assumes: straps and bpp_sel steady outside reset and runs
// Notes: identity params must match the design instance
`timescale 1ns/10ps
module packed_pixel_buffer_id_assertions #(
  parameter [5:0] PRODUCT_CODE = 6'h15,
  parameter [1:0] REVISION_CODE = 2'h1,
  parameter [7:0] BUF_SIZE_CODE = 8'h11
) (
  input wire core_clk,
  input wire srst,
  input wire [6:0] config_strap_pins,
  input wire host_cs,
  input wire host_we,
  input wire host_rvalid,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_rdata,
  input wire reg_rvalid,
  input wire scan_start,
  input wire [17:0] scan_count,
  input wire scan_busy,
  input wire [2:0] bpp_sel,
  input wire pix_valid,
  input wire pix_ready,
  input wire [15:0] pix_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_id_prod;
    reg_rd && reg_addr == 8'h00 |=>
      reg_rdata[7:2] == PRODUCT_CODE && reg_rdata[31:26] == PRODUCT_CODE;
  endproperty
  a_id_prod: assert property (p_id_prod) else $error("product code");
  property p_id_rev;
    reg_rd && reg_addr == 8'h00 |=>
      reg_rdata[1:0] == REVISION_CODE && reg_rdata[25:24] == REVISION_CODE;
  endproperty
  a_id_rev: assert property (p_id_rev) else $error("revision code");
  property p_id_size;
    reg_rd && reg_addr == 8'h00 |=> reg_rdata[15:8] == BUF_SIZE_CODE;
  endproperty
  a_id_size: assert property (p_id_size) else $error("size field");
  property p_reg_rd;
    reg_rd |=> reg_rvalid;
  endproperty
  a_reg_rd: assert property (p_reg_rd) else $error("register answer missing");
  property p_reg_quiet;
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_reg_quiet: assert property (p_reg_quiet) else $error("register answer unasked");
  property p_id_strap;
    reg_rd && reg_addr == 8'h00 |=> reg_rdata[22:16] == $past(config_strap_pins);
  endproperty
  a_id_strap: assert property (p_id_strap) else $error("strap field");
  property p_host_rd;
    host_cs && !host_we |=> host_rvalid;
  endproperty
  a_host_rd: assert property (p_host_rd) else $error("read answer");
  property p_start;
    scan_start && !scan_busy && scan_count != 18'h00000 && bpp_sel != 3'h4 |=>
      scan_busy ##2 pix_valid;
  endproperty
  a_start: assert property (p_start) else $error("first pixel late");
  property p_hold;
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data);
  endproperty
  a_hold: assert property (p_hold) else $error("pixel not held");
  property p_one;
    pix_valid && bpp_sel == 3'h0 |-> pix_data <= 16'h0001;
  endproperty
  a_one: assert property (p_one) else $error("1 bpp index range");
  property p_two;
    pix_valid && bpp_sel == 3'h1 |-> pix_data <= 16'h0003;
  endproperty
  a_two: assert property (p_two) else $error("2 bpp index range");
endmodule // packed_pixel_buffer_id_assertions

//--- sim/host_cpu_model.sv
// Purpose: host processor on the byte port of the display buffer
// Assumes: one access per call, answer registered on the taking edge and read 1 ns after it
// Notes: released lines show inverted values so stale data is not mistaken
`timescale 1ns/10ps
module host_cpu_model (
  input wire core_clk,
  input wire [7:0] host_rdata,
  output logic host_cs,
  output logic host_we,
  output logic [17:0] host_addr,
  output logic [7:0] host_wdata
);
  initial begin
    host_cs = 1'b0;
    host_we = 1'b0;
    host_addr = 18'h00000;
    host_wdata = 8'h00;
  end
  task automatic access(input logic we, input logic [17:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge core_clk);
    #1;
    host_cs = 1'b1;
    host_we = we;
    host_addr = a;
    host_wdata = d;
    @(posedge core_clk);
    #1;
    q = host_rdata;
    host_cs = 1'b0;
    host_we = ~we;
    host_addr = ~a;
    host_wdata = ~d;
  endtask
  // one small pixel changed by whole-byte read, merge, write back
  task automatic rmw(input logic [17:0] a, input logic [7:0] mask, input logic [7:0] v);
    logic [7:0] q;
    access(1'b0, a, 8'h00, q);
    access(1'b1, a, (q & ~mask) | (v & mask), q);
  endtask
endmodule // host_cpu_model

//--- sim/packed_pixel_buffer_id_test.sv
// Purpose: self-checking bench for the pixel buffer block
// Assumes: top eight bytes of buffer used for scans; no scan reads past the address boundary
// Notes: sink stalls one cycle before every take
`timescale 1ns/10ps
module packed_pixel_buffer_id_test;
  localparam [17:0] BASE = 18'h27FF8;
  localparam [5:0] PC = 6'h2A; // arbitrary
  localparam [1:0] RC = 2'h2; // arbitrary
  localparam [7:0] SC = 8'h33; // arbitrary
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [6:0] straps = 7'h5A;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic scan_start = 1'b0;
  logic [17:0] scan_base = 18'h00000;
  logic [17:0] scan_count = 18'h00000;
  logic [2:0] bpp_sel = 3'h0;
  logic mono_panel = 1'b0;
  logic pix_ready = 1'b0;
  wire host_cs, host_we, host_rvalid, reg_rvalid, scan_busy, pix_valid, pix_bypass, pix_green_only;
  wire [17:0] host_addr;
  wire [7:0] host_wdata, host_rdata;
  wire [31:0] reg_rdata;
  wire [15:0] pix_data;
  int err_total = 0;
  int checks = 0;
  logic [7:0] img [0:7] = '{8'hB1, 8'h4E, 8'h3C, 8'h96, 8'hF0, 8'h0F, 8'h69, 8'hC3};
  logic [7:0] q;
  logic [31:0] rd;
  int nt [0:4] = '{10, 8, 5, 3, 2};
  always #5 core_clk = ~core_clk;
  packed_pixel_buffer_id #(.PRODUCT_CODE(PC), .REVISION_CODE(RC), .BUF_SIZE_CODE(SC))
  i_packed_pixel_buffer_id (.core_clk(core_clk), .srst(srst), .config_strap_pins(straps),
    .host_cs(host_cs), .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .scan_start(scan_start),
    .scan_base(scan_base), .scan_count(scan_count), .bpp_sel(bpp_sel),
    .mono_panel(mono_panel), .scan_busy(scan_busy), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data), .pix_bypass(pix_bypass),
    .pix_green_only(pix_green_only));
  host_cpu_model i_host_cpu_model (.core_clk(core_clk), .host_rdata(host_rdata),
    .host_cs(host_cs), .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
  task automatic scan(input logic [2:0] b, input int n, input logic mono);
    int w, t;
    logic [15:0] e;
    w = 1 << b;
    @(posedge core_clk);
    #1;
    scan_base = BASE;
    scan_count = 18'(n);
    bpp_sel = b;
    mono_panel = mono;
    scan_start = 1'b1;
    @(posedge core_clk);
    #1;
    scan_start = 1'b0;
    for (int i = 0; i < n; i++) begin
      t = 0;
      while (pix_valid !== 1'b1 && t < 20) begin
        @(posedge core_clk);
        #1;
        t++;
      end
      if (b == 3'h4) e = {img[2*i+1], img[2*i]};
      else e = 16'((img[i*w/8] >> (8 - w - (i*w) % 8)) & ((1 << w) - 1));
      check(pix_data, e, "pixel");
      check(pix_bypass, b == 3'h4, "bypass");
      check(pix_green_only, mono, "green only");
      @(posedge core_clk);
      #1;
      pix_ready = 1'b1;
      @(posedge core_clk);
      #1;
      pix_ready = 1'b0;
    end
    t = 0;
    while (scan_busy !== 1'b0 && t < 10) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    check(scan_busy, 1'b0, "run end");
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    srst = 1'b0;
    reg_read(8'h00, rd);
    check(reg_rvalid, 1'b1, "reg answer");
    check(rd, {PC, RC, 1'b0, 7'h5A, SC, PC, RC}, "id word");
    reg_read(8'h04, rd);
    check(rd, 32'h0000_0000, "unmapped");
    for (int i = 0; i < 8; i++) i_host_cpu_model.access(1'b1, BASE + 18'(i), img[i], q);
    i_host_cpu_model.access(1'b1, 18'h28000, 8'h77, q);
    i_host_cpu_model.access(1'b0, 18'h28000, 8'h00, q);
    check(q, 8'h00, "out of range");
    check(host_rvalid, 1'b1, "host answer");
    i_host_cpu_model.rmw(BASE + 18'h1, 8'h0C, 8'h08);
    img[1] = (img[1] & 8'hF3) | 8'h08;
    for (int i = 0; i < 8; i++) begin
      i_host_cpu_model.access(1'b0, BASE + 18'(i), 8'h00, q);
      check(q, img[i], "readback");
    end
    // every depth, runs ending mid-byte at 1 and 4 bpp, on a byte end at 2 bpp
    for (int b = 0; b < 5; b++) scan(3'(b), nt[b], b[0]);
    // second reset with other strap levels; a fixed seven-bit strap field would fail here
    straps = 7'h25;
    srst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    srst = 1'b0;
    reg_read(8'h00, rd);
    check(rd, {PC, RC, 1'b0, 7'h25, SC, PC, RC}, "id word after reset");
    finish_test;
  end
  initial begin
    #100000;
    err_total++;
    $display("MISMATCH t=%0t watchdog", $time);
    finish_test;
  end
endmodule // packed_pixel_buffer_id_test
bind packed_pixel_buffer_id packed_pixel_buffer_id_assertions #(
  .PRODUCT_CODE(PRODUCT_CODE), .REVISION_CODE(REVISION_CODE), .BUF_SIZE_CODE(BUF_SIZE_CODE))
  i_packed_pixel_buffer_id_assertions (.core_clk(core_clk), .srst(srst),
  .config_strap_pins(config_strap_pins), .host_cs(host_cs), .host_we(host_we),
  .host_rvalid(host_rvalid), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .scan_start(scan_start), .scan_count(scan_count), .scan_busy(scan_busy), .bpp_sel(bpp_sel),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data));
